// >>> design/break_idle_pkg.sv
/*
 Package for the asynchronous serial break and idle transmitter: frame lengths, counter widths,
 reset values and the state carrier. Assumes a single 10 MHz clock and synchronous inputs.
*/
// Summary of operation
// - Eight-bit mode break lasts exactly 10 bits
// - Nine-bit mode break lasts exactly 11 bits
// - Break characters repeat while break bit set
// - Enable low-then-high queues one idle frame
// - Queued idle goes first, then exact break
package break_idle_pkg;
	localparam int BAUD_W = 16;
	localparam logic [3:0] FRAME_BITS_8 = 4'hA;
	localparam logic [3:0] FRAME_BITS_9 = 4'hB;
	localparam logic [BAUD_W-1:0] BAUD_DIV_RESET = 16'h0001;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_IDLE_FRAME = 3'b010,
		ST_BREAK = 3'b100
	} tx_state_t;

	typedef struct packed {
		tx_state_t state;
		logic [BAUD_W-1:0] baud_cnt;
		logic [3:0] bit_cnt;
		logic [3:0] frame_len;
		logic idle_pending;
		logic break_pending;
		logic enable_prev;
		logic break_prev;
		logic tx_line;
		logic busy;
	} tx_regs_t;
endpackage : break_idle_pkg

// >>> design/async_serial_break_idle_tx.sv
/*
 Break and idle generator for the serial transmit pin. Control bits are plain inputs, taken
 synchronous to ref_clk. A bit time is baud_div+1 clocks; baud_div is held stable while busy.
*/
`timescale 1ns/100ps
module async_serial_break_idle_tx
	import break_idle_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Software control bits
	input wire logic break_send_bit,
	input wire logic transmitter_enable_bit,
	input wire logic word_length_sel,
	input wire logic [BAUD_W-1:0] baud_div,
	// Line and status
	output logic tx_pin,
	output logic tx_busy
);
	tx_regs_t r;
	tx_regs_t next_r;
	logic bit_end;
	logic frame_end;

	assign bit_end = (r.baud_cnt == baud_div);
	assign frame_end = bit_end && (r.bit_cnt == r.frame_len - 4'h1);
	assign tx_pin = r.tx_line;
	assign tx_busy = r.busy;

	// Next-state logic: request capture, then frame sequencing
	always_comb begin
		next_r = r;
		next_r.enable_prev = transmitter_enable_bit;
		next_r.break_prev = break_send_bit;
		if (transmitter_enable_bit && !r.enable_prev)
			next_r.idle_pending = 1'b1;
		if (break_send_bit && !r.break_prev)
			next_r.break_pending = 1'b1;
		unique case (r.state)
			ST_IDLE: begin
				next_r.baud_cnt = '0;
				next_r.bit_cnt = 4'h0;
				next_r.frame_len = word_length_sel ? FRAME_BITS_9 : FRAME_BITS_8;
				if (r.idle_pending && transmitter_enable_bit) begin
					next_r.state = ST_IDLE_FRAME;
					next_r.idle_pending = 1'b0;
					next_r.tx_line = 1'b1;
					next_r.busy = 1'b1;
				end else if (r.break_pending || break_send_bit) begin
					next_r.state = ST_BREAK;
					next_r.break_pending = 1'b0;
					next_r.tx_line = 1'b0;
					next_r.busy = 1'b1;
				end else begin
					next_r.tx_line = 1'b1;
					next_r.busy = 1'b0;
				end
			end
			ST_IDLE_FRAME, ST_BREAK: begin
				next_r.baud_cnt = bit_end ? '0 : r.baud_cnt + 16'h0001;
				if (bit_end)
					next_r.bit_cnt = r.bit_cnt + 4'h1;
				if (frame_end) begin
					// Frame ends: pin back high, one clean idle-high clock
					next_r.state = ST_IDLE;
					next_r.tx_line = 1'b1;
					next_r.busy = 1'b0;
					if (r.state == ST_BREAK)
						next_r.break_pending = 1'b0;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			// Line parks high and no request is held over a reset
			r <= '{
				state: ST_IDLE,
				baud_cnt: '0,
				bit_cnt: 4'h0,
				frame_len: FRAME_BITS_8,
				idle_pending: 1'b0,
				break_pending: 1'b0,
				enable_prev: 1'b0,
				break_prev: 1'b0,
				tx_line: 1'b1,
				busy: 1'b0
			};
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	// Low stretch measured in clocks while enabled
	logic [19:0] low_clocks;
	always_ff @(posedge ref_clk) begin
		if (reset)
			low_clocks <= '0;
		else if (clk_en)
			low_clocks <= r.tx_line ? 20'h00000 : low_clocks + 20'h00001;
	end

	// Clocks spent in the current frame, cleared between frames
	logic [19:0] frame_clocks;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			frame_clocks <= '0;
		end else if (clk_en) begin
			frame_clocks <= (r.state == ST_IDLE) ? 20'h00000 : frame_clocks + 20'h00001;
		end
	end

	// A frame reaching its last enabled clock
	sequence s_frame_done;
		clk_en && r.state != ST_IDLE && frame_end;
	endsequence

	// A break reaching its last enabled clock
	sequence s_break_done;
		clk_en && r.state == ST_BREAK && frame_end;
	endsequence

	// Idle state followed by a break start
	sequence s_break_start;
		r.state == ST_IDLE ##1 r.state == ST_BREAK;
	endsequence

	a_break_len_eight: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && r.state == ST_BREAK && frame_end && r.frame_len == FRAME_BITS_8)
		|-> (low_clocks + 20'd1 == 20'(32'(FRAME_BITS_8) * (32'(baud_div) + 32'd1))))
		else $error("break length wrong in eight-bit mode");
	a_break_len_nine: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && r.state == ST_BREAK && frame_end && r.frame_len == FRAME_BITS_9)
		|-> low_clocks + 20'd1 == 20'(32'(FRAME_BITS_9) * (32'(baud_div) + 32'd1)))
		else $error("break length wrong in nine-bit mode");
	a_break_line_low: assert property (@(posedge ref_clk) disable iff (reset)
		(r.state == ST_BREAK) |-> !tx_pin)
		else $error("line high during break");
	a_break_repeats: assert property (@(posedge ref_clk) disable iff (reset)
		s_break_done ##1 (clk_en && break_send_bit && !(r.idle_pending && transmitter_enable_bit))
		|=> r.state == ST_BREAK)
		else $error("held break bit did not repeat");
	a_idle_high: assert property (@(posedge ref_clk) disable iff (reset)
		(r.state == ST_IDLE_FRAME) |-> tx_pin)
		else $error("line low during idle frame");
	a_idle_first: assert property (@(posedge ref_clk) disable iff (reset)
		(r.state == ST_IDLE && r.idle_pending && transmitter_enable_bit && clk_en)
		|=> r.state == ST_IDLE_FRAME)
		else $error("idle frame not sent first");
	a_idle_queued: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && transmitter_enable_bit && !r.enable_prev) |=> r.idle_pending || r.state == ST_IDLE_FRAME)
		else $error("enable toggle did not queue idle");
	a_break_begins: assert property (@(posedge ref_clk) disable iff (reset)
		s_break_start |-> !tx_pin && tx_busy)
		else $error("break start not driven");

	// Reset leaves the line idle high and not busy
	a_reset_line_high: assert property (@(posedge ref_clk)
		$past(reset) |-> tx_pin && !tx_busy)
		else $error("line not idle after reset");

	// Clock enable low freezes every state bit
	a_freeze_state: assert property (@(posedge ref_clk) disable iff (reset)
		!clk_en |=> $stable(r))
		else $error("state moved while clock enable low");

	// Busy flag mirrors a frame on the line
	a_busy_tracks_state: assert property (@(posedge ref_clk) disable iff (reset)
		tx_busy == (r.state != ST_IDLE))
		else $error("busy flag out of step with frame");

	// Bit-time counter stays inside one bit time
	a_baud_in_range: assert property (@(posedge ref_clk) disable iff (reset)
		(r.state != ST_IDLE) |-> r.baud_cnt <= baud_div)
		else $error("bit-time counter overran");

	// Bit counter stays inside the frame
	a_bit_in_range: assert property (@(posedge ref_clk) disable iff (reset)
		(r.state != ST_IDLE) |-> r.bit_cnt < r.frame_len)
		else $error("bit counter overran frame");

	// Frame length is fixed once a frame runs
	a_frame_len_fixed: assert property (@(posedge ref_clk) disable iff (reset)
		(r.state != ST_IDLE) ##1 (r.state != ST_IDLE) |-> $stable(r.frame_len))
		else $error("frame length changed mid-frame");

	// Break length counted over the whole frame
	a_break_frame_len: assert property (@(posedge ref_clk) disable iff (reset)
		s_break_done |-> frame_clocks + 20'd1 == 20'(32'(r.frame_len) * (32'(baud_div) + 32'd1)))
		else $error("break frame length wrong");

	// Idle frame has the nominal length too
	a_idle_frame_len: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && r.state == ST_IDLE_FRAME && frame_end)
		|-> frame_clocks + 20'd1 == 20'(32'(r.frame_len) * (32'(baud_div) + 32'd1)))
		else $error("idle frame length wrong");

	// Each frame is followed by an idle-high clock
	a_gap_after_frame: assert property (@(posedge ref_clk) disable iff (reset)
		s_frame_done |=> r.state == ST_IDLE && tx_pin && !tx_busy)
		else $error("no idle clock after frame");

	// Break ends with the line back high
	a_break_ends_high: assert property (@(posedge ref_clk) disable iff (reset)
		s_break_done |=> tx_pin)
		else $error("line low after break end");

	// Break bit already cleared gives no second break
	a_single_break: assert property (@(posedge ref_clk) disable iff (reset)
		s_break_done ##1 (clk_en && !break_send_bit && !r.break_pending) |=> r.state != ST_BREAK)
		else $error("doubled break after clear");

	// A held-over break follows the idle frame
	a_pending_break_runs: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && r.state == ST_IDLE && r.break_pending && !(r.idle_pending && transmitter_enable_bit))
		|=> r.state == ST_BREAK)
		else $error("held break not sent");

	// No idle frame while the transmitter is off
	a_no_enable_no_idle: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && r.state == ST_IDLE && !transmitter_enable_bit) |=> r.state != ST_IDLE_FRAME)
		else $error("idle frame with transmitter off");

	// Quiet control bits keep the line parked high
	a_quiet_line_high: assert property (@(posedge ref_clk) disable iff (reset)
		(clk_en && r.state == ST_IDLE && !r.idle_pending && !r.break_pending && !break_send_bit)
		|=> tx_pin && r.state == ST_IDLE)
		else $error("line left idle without request");

	// Trading note: the checks above assume baud_div is held while busy,
	// as a change mid-frame would stretch or cut the current bit time.
	// The low and frame counters wrap only past 20 bits of clocks,
	// above the longest frame, 11 bits of 65536 clocks, at the widest bit time.
endmodule : async_serial_break_idle_tx

// >>> testbench/line_rx_model.sv
/*
 Far-end receiver model: times each low run on the line in clocks.
 Assumes it shares ref_clk with the transmitter and only listens.
*/
`timescale 1ns/100ps
module line_rx_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Line in, measurements out
	input wire logic tx_pin,
	output logic [7:0] low_len,
	output logic [7:0] n_low
);
	logic [7:0] run;
	// Time low runs, publish length on return to high
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			run <= 8'h00;
			low_len <= 8'h00;
			n_low <= 8'h00;
		end else if (tx_pin === 1'b0) begin
			run <= run + 8'h01;
		end else if (run != 8'h00) begin
			low_len <= run;
			n_low <= n_low + 8'h01;
			run <= 8'h00;
		end
	end
endmodule : line_rx_model

// >>> testbench/tb_top.sv
/*
 Bench for the break and idle transmitter.
 Assumes the line model beside it and a 10 MHz clock; a bit time is 2 clocks.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected %0t got %h want %h", $time, a, e); end end
module tb_top
	import break_idle_pkg::*;
;
	logic ref_clk = 1'b0, reset = 1'b1, brk = 1'b0, en = 1'b0, wls = 1'b0, tx_pin, tx_busy;
	logic [7:0] low_len, n_low;
	int n_mismatch = 0, n_checks = 0, cyc = 0, k;
	logic [8:0] rows [2] = '{{1'b0, 8'h14}, {1'b1, 8'h16}};
	always #50 ref_clk = ~ref_clk;
	async_serial_break_idle_tx dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .break_send_bit(brk),
		.transmitter_enable_bit(en), .word_length_sel(wls), .baud_div(16'h0001), .tx_pin(tx_pin), .tx_busy(tx_busy));
	line_rx_model rx_u (.ref_clk(ref_clk), .reset(reset), .tx_pin(tx_pin), .low_len(low_len), .n_low(n_low));
	// Bounded waits on the busy flag
	task rise; for (k = 0; k < 10 && tx_busy !== 1'b1; k++) @(negedge ref_clk); if (tx_busy !== 1'b1) n_mismatch++; endtask : rise
	task fall; for (k = 0; k < 100 && tx_busy !== 1'b0; k++) @(negedge ref_clk); if (tx_busy !== 1'b0) n_mismatch++; endtask : fall
	task pulse; brk = 1'b1; @(negedge ref_clk); brk = 1'b0; endtask : pulse
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_mismatch++;
			end_of_test;
		end
	end
	initial begin
		repeat (4) @(negedge ref_clk);
		reset = 1'b0;
		`CHK(tx_pin, 1'b1)
		en = 1'b1;
		rise;
		`CHK(tx_busy, 1'b1)
		`CHK(tx_pin, 1'b1)
		fall;
		`CHK(n_low, 8'h00)
		// Single break per word length
		for (int i = 0; i < 2; i++) begin
			wls = rows[i][8];
			pulse;
			rise;
			fall;
			@(negedge ref_clk);
			`CHK(low_len, rows[i][7:0])
			`CHK(tx_pin, 1'b1)
		end
		// Enable toggle right before a break
		wls = 1'b0;
		en = 1'b0;
		@(negedge ref_clk);
		en = 1'b1;
		@(negedge ref_clk);
		pulse;
		rise;
		`CHK(tx_pin, 1'b1)
		fall;
		rise;
		fall;
		@(negedge ref_clk);
		`CHK(low_len, 8'h14)
		`CHK(n_low, 8'h03)
		// Held break repeats, cleared mid-break
		brk = 1'b1;
		rise;
		fall;
		rise;
		brk = 1'b0;
		fall;
		@(negedge ref_clk);
		`CHK(n_low, 8'h05)
		`CHK(low_len, 8'h14)
		// Reset in mid-break parks the line
		brk = 1'b1;
		rise;
		reset = 1'b1;
		brk = 1'b0;
		@(negedge ref_clk);
		reset = 1'b0;
		`CHK(tx_pin, 1'b1)
		`CHK(tx_busy, 1'b0)
		end_of_test;
	end
endmodule : tb_top
